// >>> hope_defs.svh
// offsets, field positions, reset values and codes of the hdlc overhead engine
`ifndef HOPE_DEFS_SVH
`define HOPE_DEFS_SVH
`define HOPE_OFS_CTRL    4'h0
`define HOPE_OFS_THR     4'h4
`define HOPE_OFS_STAT    4'h8
`define HOPE_OFS_RXD     4'hc
`define HOPE_C_TXSTART   0
`define HOPE_C_TXREORD   1
`define HOPE_C_TXFCS     2
`define HOPE_C_TXFCSERR  3
`define HOPE_C_TXONES    4
`define HOPE_C_TXINV     5
`define HOPE_C_RXINV     6
`define HOPE_C_RXREORD   7
`define HOPE_C_RXFCS     8
`define HOPE_CTRL_RST    9'h105
`define HOPE_THR_RST     8'h01
`define HOPE_S_OVF       3
`define HOPE_S_INV       4
`define HOPE_FLAG        8'h7e
`define HOPE_ABORT       8'hff
`define HOPE_CRC_POLY    16'h8408
`define HOPE_CRC_INIT    16'hffff
`define HOPE_CRC_GOOD    16'hf0b8
`define HOPE_ONES_MIN    5'h0f
`define HOPE_MIN_BITS    5'h10
`define HOPE_FREE_LVL    9'h0f0
`define HOPE_ENT_ABTEOP  12'h600
`define HOPE_RESP_OK     2'b00
`define HOPE_RESP_ERR    2'b10
`endif

// >>> hope_pkg.sv
// types of the hdlc overhead engine
package hope_pkg;
  typedef enum logic [2:0] {TX_FILL, TX_DATA, TX_FCS_LO, TX_FCS_HI, TX_EFLAG} hope_tx_st_t;
  typedef struct packed {
    logic       fcs_err;
    logic       abort;
    logic       eop;
    logic       sop;
    logic [7:0] data;
  } hope_entry_t;
endpackage : hope_pkg

// >>> hope_engine.sv
// hdlc overhead packet engine: tx framer, rx deframer, rx fifo, axi4-lite regs
// How it works
// - after packet end, idle fill if start unready
// - empty fifo read mid-packet aborts stream
// - fill until two bytes and start enabled
// - tx reorder picks bit 0 or 7 first
// - append inverted crc-16 when fcs enabled
// - error mode appends raw crc; off appends none
// - stuff zero after five ones in packet
// - flag fill sends flags until packet start
// - ones fill: end flag, fifteen ones, start flag
// - back-to-back packets get exactly two flags
// - abort sends ffh then inter-frame fill
// - tx inverted last, rx inverted first
// - rx hunts flag at every bit position
// - rx drops fill and gaps under sixteen bits
// - seven ones abort packet until next flag
// - rx deletes stuffed zeros, packs tagged bytes
// - partial last byte flags invalid and abort
// - rx checks and strips fcs when enabled
// - rx reorder puts first bit at 0 or 7
// - 256-entry rx fifo with empty/full/avail
// - overflow drops or aborts until 16 free
// - empty fifo read returns invalid, no effect
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "hope_defs.svh"
module hope_engine (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  // transmit fifo, show-ahead
  input  wire logic [7:0]  tx_fifo_byte,
  input  wire logic        tx_fifo_eop,
  input  wire logic [8:0]  tx_fifo_level,
  output wire logic        tx_fifo_rd,
  output wire logic        tx_fill,
  // framer overhead bits
  input  wire logic        tx_bit_en,
  output wire logic        tx_bit,
  input  wire logic        rx_bit_en,
  input  wire logic        rx_bit_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // register state
  logic [8:0]  ctrl_r;
  logic [7:0]  thr_r;
  logic        ovf_r, inval_r;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  // control fields
  wire c_start   = ctrl_r[`HOPE_C_TXSTART];
  wire c_treord  = ctrl_r[`HOPE_C_TXREORD];
  wire c_tfcs    = ctrl_r[`HOPE_C_TXFCS];
  wire c_fcserr  = ctrl_r[`HOPE_C_TXFCSERR];
  wire c_ones    = ctrl_r[`HOPE_C_TXONES];
  wire c_tinv    = ctrl_r[`HOPE_C_TXINV];
  wire c_rinv    = ctrl_r[`HOPE_C_RXINV];
  wire c_rreord  = ctrl_r[`HOPE_C_RXREORD];
  wire c_rfcs    = ctrl_r[`HOPE_C_RXFCS];
  // ---------------- transmit ----------------
  hope_pkg::hope_tx_st_t tst_r, n_st;
  logic [7:0]  sh_r, n_sh;
  logic [3:0]  cnt_r, n_cnt;
  logic        stf_r, n_stf, crc_on_r, n_crc, n_rd;
  logic [2:0]  tones_r;
  logic [15:0] tcrc_r;
  logic [4:0]  fones_r;
  logic        tx_bit_r, tx_rd_r, tx_fill_r;
  logic [7:0]  trev_w, rrev_w, rx_byte_w;
  // per-bit reversal for both reorder paths
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign trev_w[gi] = tx_fifo_byte[7-gi];
      assign rrev_w[gi] = rx_byte_w[7-gi];
    end
  endgenerate
  // serializer decode
  wire        stuff_w  = (tones_r == 3'h5);
  wire        out_w    = stuff_w ? 1'b0 : sh_r[0];
  wire        last_w   = tx_bit_en && !stuff_w && (cnt_r == 4'h1);
  wire        start_ok = (tx_fifo_level >= 9'h002) && c_start;
  wire [7:0]  tbyte_w  = c_treord ? trev_w : tx_fifo_byte;
  wire        tfb_w    = tcrc_r[0] ^ sh_r[0];
  wire [15:0] tcrc_upd = {1'b0, tcrc_r[15:1]} ^ (tfb_w ? `HOPE_CRC_POLY : 16'h0000);
  wire [15:0] crc_nx_w = crc_on_r ? tcrc_upd : tcrc_r;
  wire [15:0] fcs_w    = c_fcserr ? crc_nx_w : ~crc_nx_w;
  // next item to serialize, chosen as the current one ends
  always_comb begin
    n_sh  = `HOPE_FLAG;
    n_cnt = 4'h8;
    n_stf = 1'b0;
    n_crc = 1'b0;
    n_rd  = 1'b0;
    n_st  = tst_r;
    case (tst_r)
      hope_pkg::TX_FILL: begin
        if (start_ok && (!c_ones || fones_r >= `HOPE_ONES_MIN)) begin
          n_st = hope_pkg::TX_DATA;
        end else if (c_ones) begin
          n_sh  = 8'h01;
          n_cnt = 4'h1;
        end                                                     // else flags
      end
      hope_pkg::TX_DATA: begin
        if (tx_fifo_level == 9'h000) begin
          n_sh = `HOPE_ABORT;
          n_st = hope_pkg::TX_FILL;
        end else begin
          n_sh  = tbyte_w;
          n_stf = 1'b1;
          n_crc = 1'b1;
          n_rd  = 1'b1;
          if (tx_fifo_eop) begin
            n_st = c_tfcs ? hope_pkg::TX_FCS_LO : hope_pkg::TX_EFLAG;
          end
        end
      end
      hope_pkg::TX_FCS_LO: begin
        n_sh  = fcs_w[7:0];
        n_stf = 1'b1;
        n_st  = hope_pkg::TX_FCS_HI;
      end
      hope_pkg::TX_FCS_HI: begin
        n_sh  = fcs_w[15:8];
        n_stf = 1'b1;
        n_st  = hope_pkg::TX_EFLAG;
      end
      hope_pkg::TX_EFLAG: n_st = hope_pkg::TX_FILL;
      default: n_st = hope_pkg::TX_FILL;
    endcase
  end
  // serializer, stuffing and crc on each framer strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tst_r     <= hope_pkg::TX_FILL;
      sh_r      <= 8'hff;
      cnt_r     <= 4'h1;
      stf_r     <= 1'b0;
      crc_on_r  <= 1'b0;
      tones_r   <= 3'h0;
      tcrc_r    <= `HOPE_CRC_INIT;
      fones_r   <= 5'h00;
      tx_bit_r  <= 1'b1;
      tx_rd_r   <= 1'b0;
      tx_fill_r <= 1'b1;
    end else begin
      tx_rd_r   <= last_w && n_rd;
      tx_fill_r <= (tst_r == hope_pkg::TX_FILL);
      if (tx_bit_en) begin
        tx_bit_r <= out_w ^ c_tinv;
        tones_r  <= (!stuff_w && stf_r && sh_r[0]) ? tones_r + 3'h1 : 3'h0;
      end
      if (tx_bit_en && !stuff_w) begin
        tcrc_r <= (tst_r == hope_pkg::TX_FILL) ? `HOPE_CRC_INIT : crc_nx_w;
      end
      if (last_w) begin
        tst_r    <= n_st;
        sh_r     <= n_sh;
        cnt_r    <= n_cnt;
        stf_r    <= n_stf;
        crc_on_r <= n_crc;
        if (tst_r != hope_pkg::TX_FILL) fones_r <= 5'h00;
        else if (c_ones && fones_r != `HOPE_ONES_MIN) fones_r <= fones_r + 5'h01;
      end else if (tx_bit_en && !stuff_w) begin
        sh_r  <= {1'b0, sh_r[7:1]};
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  // ---------------- receive ----------------
  logic [6:0]  rh_r, dly_r;
  logic [2:0]  rones_r, bc_r;
  logic [3:0]  dn_r;
  logic [7:0]  asm_r;
  logic [4:0]  nbits_r;
  logic [23:0] hs_r;
  logic [1:0]  hn_r;
  logic        rin_r, sop_sent_r;
  logic [15:0] rcrc_r;
  // line decode: inversion, flag, abort, destuff
  wire        rb      = rx_bit_in ^ c_rinv;
  wire        flag_w  = ({rh_r, rb} == `HOPE_FLAG);
  wire        abort_w = rb && (rones_r == 3'h6);
  wire        del_w   = !rb && (rones_r == 3'h5);
  wire        dv_w    = rin_r && !flag_w && !abort_w && !del_w;
  wire        rel_w   = dv_w && (dn_r == 4'h7);
  wire        rel_bit = dly_r[0];
  wire        byte_dn = rel_w && (bc_r == 3'h7);
  wire [7:0]  byte_w  = {rel_bit, asm_r[7:1]};
  wire        rfb_w   = rcrc_r[0] ^ rel_bit;
  wire [15:0] rcrc_nx = {1'b0, rcrc_r[15:1]} ^ (rfb_w ? `HOPE_CRC_POLY : 16'h0000);
  // held bytes hide the fcs and carry the end tag
  wire [1:0]  hdep_w  = c_rfcs ? 2'h3 : 2'h1;
  assign rx_byte_w    = (hn_r == 2'h1) ? hs_r[7:0] :
                        (hn_r == 2'h2) ? hs_r[15:8] : hs_r[23:16];
  wire        end_ok  = rx_bit_en && flag_w && rin_r && (nbits_r == `HOPE_MIN_BITS);
  wire        bad_len = end_ok && (bc_r != 3'h0);
  wire        ps_data = rx_bit_en && byte_dn && (hn_r == hdep_w);
  wire        ps_end  = end_ok && (hn_r == hdep_w);
  wire        ps_abt  = rx_bit_en && rin_r && abort_w && sop_sent_r;
  wire        psh_w   = ps_data || ps_end || ps_abt;
  wire        fcs_bad = ps_end && !bad_len && c_rfcs && (rcrc_r != `HOPE_CRC_GOOD);
  hope_pkg::hope_entry_t pent_w;
  assign pent_w = {fcs_bad, ps_abt || bad_len, !ps_data, !sop_sent_r,
                   c_rreord ? rrev_w : rx_byte_w};
  // deframer: delay line hides the flag bits, bytes packed lsb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rh_r <= 7'h00;  rones_r <= 3'h0;  rin_r <= 1'b0;
      dly_r <= 7'h00; dn_r <= 4'h0;     asm_r <= 8'h00;
      bc_r <= 3'h0;   nbits_r <= 5'h00; hs_r <= 24'h000000;
      hn_r <= 2'h0;   sop_sent_r <= 1'b0;
      rcrc_r <= `HOPE_CRC_INIT;
    end else if (rx_bit_en) begin
      rh_r    <= {rh_r[5:0], rb};
      rones_r <= !rb ? 3'h0 : (rones_r == 3'h7) ? rones_r : rones_r + 3'h1;
      if (flag_w) begin
        rin_r <= 1'b1;  dn_r <= 4'h0;  bc_r <= 3'h0;  nbits_r <= 5'h00;
        hn_r <= 2'h0;   sop_sent_r <= 1'b0;
        rcrc_r <= `HOPE_CRC_INIT;
      end else if (rin_r && abort_w) begin
        rin_r <= 1'b0;
      end else if (dv_w) begin
        dly_r <= {rb, dly_r[6:1]};
        if (dn_r != 4'h7) dn_r <= dn_r + 4'h1;
        if (rel_w) begin
          asm_r  <= byte_w;
          bc_r   <= bc_r + 3'h1;
          rcrc_r <= rcrc_nx;
          if (nbits_r != `HOPE_MIN_BITS) nbits_r <= nbits_r + 5'h01;
        end
        if (byte_dn) begin
          hs_r <= {hs_r[15:0], byte_w};
          if (hn_r != hdep_w) hn_r <= hn_r + 2'h1;
          if (ps_data) sop_sent_r <= 1'b1;
        end
      end
    end
  end
  // ---------------- receive fifo ----------------
  hope_pkg::hope_entry_t mem_r [0:255];
  logic [7:0] wptr_r, rptr_r;
  logic [8:0] fcnt_r;
  logic       drop_r;
  // fill flags and accept decisions
  wire        full_w  = fcnt_r[8];
  wire        empty_w = (fcnt_r == 9'h000);
  wire        avail_w = (fcnt_r >= {1'b0, thr_r});
  wire        ovf_evt = psh_w && full_w;
  wire        acc_w   = psh_w && !full_w &&
                        (!drop_r || (pent_w.sop && fcnt_r <= `HOPE_FREE_LVL));
  wire        mark_w  = ovf_evt && !pent_w.sop && !drop_r;
  wire [7:0]  wlast_w = wptr_r - 8'h01;
  wire [11:0] mark_e  = mem_r[wlast_w] | `HOPE_ENT_ABTEOP;
  wire [11:0] rd_ent  = mem_r[rptr_r];
  // storage, one write a cycle
  always_ff @(posedge aclk) begin
    if (acc_w) mem_r[wptr_r] <= pent_w;
    else if (mark_w) mem_r[wlast_w] <= mark_e;
  end
  // ---------------- register slave ----------------
  wire       wr_go  = awvalid && wvalid && !awready_r && !bvalid_r;
  wire       rd_go  = arvalid && !arready_r && !rvalid_r;
  wire       wa_ctl = (awaddr == `HOPE_OFS_CTRL);
  wire       wa_thr = (awaddr == `HOPE_OFS_THR);
  wire       wa_st  = (awaddr == `HOPE_OFS_STAT);
  wire       ra_ctl = (araddr == `HOPE_OFS_CTRL);
  wire       ra_thr = (araddr == `HOPE_OFS_THR);
  wire       ra_st  = (araddr == `HOPE_OFS_STAT);
  wire       ra_rxd = (araddr == `HOPE_OFS_RXD);
  wire       pop_w  = rd_go && ra_rxd && !empty_w;
  wire       clr_ov = wr_go && wa_st && wstrb[0] && wdata[`HOPE_S_OVF];
  wire       clr_iv = wr_go && wa_st && wstrb[0] && wdata[`HOPE_S_INV];
  wire [31:0] rd_mux = ra_ctl ? {23'h000000, ctrl_r} :
                       ra_thr ? {24'h000000, thr_r} :
                       ra_st  ? {27'h0000000, inval_r, ovf_r, avail_w, full_w, empty_w} :
                       ra_rxd ? {19'h00000, empty_w, empty_w ? 12'h000 : rd_ent} :
                       32'h00000000;
  // pointers, level and sticky status; a new event beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_r <= 8'h00; rptr_r <= 8'h00; fcnt_r <= 9'h000; drop_r <= 1'b0;
      ovf_r <= 1'b0;   inval_r <= 1'b0;
    end else begin
      if (acc_w) wptr_r <= wptr_r + 8'h01;
      if (pop_w) rptr_r <= rptr_r + 8'h01;
      fcnt_r  <= fcnt_r + {8'h00, acc_w} - {8'h00, pop_w};
      if (ovf_evt) drop_r <= 1'b1;
      else if (acc_w) drop_r <= 1'b0;
      ovf_r   <= ovf_evt || (ovf_r && !clr_ov);
      inval_r <= bad_len || (inval_r && !clr_iv);
    end
  end
  // axi handshakes and writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0; wready_r <= 1'b0; bvalid_r <= 1'b0; bresp_r <= `HOPE_RESP_OK;
      arready_r <= 1'b0; rvalid_r <= 1'b0; rresp_r <= `HOPE_RESP_OK;
      rdata_r <= 32'h00000000;
      ctrl_r <= `HOPE_CTRL_RST; thr_r <= `HOPE_THR_RST;
    end else begin
      awready_r <= wr_go;
      wready_r  <= wr_go;
      arready_r <= rd_go;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wa_ctl || wa_thr || wa_st) ? `HOPE_RESP_OK : `HOPE_RESP_ERR;
      end else if (bready) bvalid_r <= 1'b0;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= (ra_ctl || ra_thr || ra_st || ra_rxd) ? `HOPE_RESP_OK : `HOPE_RESP_ERR;
        rdata_r  <= rd_mux;
      end else if (rready) rvalid_r <= 1'b0;
      if (wr_go && wa_ctl && wstrb[0]) ctrl_r[7:0] <= wdata[7:0];
      if (wr_go && wa_ctl && wstrb[1]) ctrl_r[8] <= wdata[8];
      if (wr_go && wa_thr && wstrb[0]) thr_r <= wdata[7:0];
    end
  end
  // outputs
  assign awready    = awready_r;
  assign wready     = wready_r;
  assign bvalid     = bvalid_r;
  assign bresp      = bresp_r;
  assign arready    = arready_r;
  assign rvalid     = rvalid_r;
  assign rresp      = rresp_r;
  assign rdata      = rdata_r;
  assign tx_fifo_rd = tx_rd_r;
  assign tx_fill    = tx_fill_r;
  assign tx_bit     = tx_bit_r;
  // ---------------- checks ----------------
  sequence s_eop_nofcs;
    last_w && tst_r == hope_pkg::TX_DATA && tx_fifo_level != 9'h000 && tx_fifo_eop && !c_tfcs;
  endsequence
  sequence s_empty_read;
    rd_go && ra_rxd && empty_w;
  endsequence

  tx_abort_a: assert property (last_w && tst_r == hope_pkg::TX_DATA && tx_fifo_level == 9'h000
    |=> sh_r == `HOPE_ABORT && tst_r == hope_pkg::TX_FILL && !stf_r)
    else $error("abort byte not sent on empty read");
  tx_start_gate_a: assert property (last_w && tst_r == hope_pkg::TX_FILL && !start_ok
    |=> tst_r == hope_pkg::TX_FILL)
    else $error("packet started without two bytes");
  tx_order_a: assert property (last_w && tst_r == hope_pkg::TX_DATA && tx_fifo_level != 9'h000
    |=> sh_r == $past(tbyte_w) && tx_rd_r ##1 !tx_rd_r)
    else $error("tx byte load or read pulse wrong");
  tx_stuff_a: assert property (tx_bit_en && stuff_w |=> tx_bit_r == $past(c_tinv))
    else $error("stuffed zero missing");
  tx_invert_a: assert property (tx_bit_en && !stuff_w
    |=> tx_bit_r == ($past(out_w) ^ $past(c_tinv)))
    else $error("tx bit inversion wrong");
  tx_no_fcs_a: assert property (s_eop_nofcs |=> tst_r == hope_pkg::TX_EFLAG)
    else $error("fcs sent while disabled");
  tx_two_flags_a: assert property (last_w && tst_r == hope_pkg::TX_FILL && start_ok && !c_ones
    |=> tst_r == hope_pkg::TX_DATA && sh_r == `HOPE_FLAG)
    else $error("start flag not sent");
  tx_ones_min_a: assert property (last_w && tst_r == hope_pkg::TX_FILL && c_ones
    && fones_r < `HOPE_ONES_MIN |=> tst_r == hope_pkg::TX_FILL && cnt_r == 4'h1 && sh_r[0])
    else $error("ones fill too short");
  rx_abort_a: assert property (rx_bit_en && rin_r && abort_w |=> !rin_r)
    else $error("seven ones did not abort");
  rx_short_a: assert property (rx_bit_en && flag_w && rin_r && nbits_r != `HOPE_MIN_BITS
    |-> !psh_w)
    else $error("short frame stored");
  rx_ovf_drop_a: assert property (psh_w && full_w |=> drop_r && ovf_r)
    else $error("overflow not declared");
  rx_empty_read_a: assert property (s_empty_read
    |=> rvalid_r && rdata_r[12] && $stable(rptr_r) && fcnt_r == $past(fcnt_r) + {8'h00, $past(acc_w)})
    else $error("empty read disturbed fifo");
endmodule : hope_engine

// >>> hope_framer_model.sv
// framer overhead slot model with transmit-to-receive loopback
`timescale 1ns/1ps
module hope_framer_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // slot pacing, high for sparse slots
  input  wire logic slow,
  // overhead bit slots
  input  wire logic tx_bit,
  output logic      tx_bit_en,
  output logic      rx_bit_en,
  output logic      rx_bit_in
);
  logic [2:0] cnt_r;
  logic       sent_r;
  // one transmit slot every two or five clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r     <= 3'h0;
      tx_bit_en <= 1'b0;
    end else begin
      cnt_r     <= (cnt_r >= (slow ? 3'h4 : 3'h1)) ? 3'h0 : cnt_r + 3'h1;
      tx_bit_en <= (cnt_r == 3'h0);
    end
  end
  // loop the sent bit back once it is visible; between slots toggle the line every clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      sent_r    <= 1'b0;
      rx_bit_en <= 1'b0;
      rx_bit_in <= 1'b1;
    end else begin
      sent_r    <= tx_bit_en;
      rx_bit_en <= sent_r;
      rx_bit_in <= sent_r ? tx_bit : ~rx_bit_in;
    end
  end
endmodule : hope_framer_model

// >>> tb.sv
// self-checking bench for the hdlc overhead engine
`timescale 1ns/1ps
`include "hope_defs.svh"
module tb;
  // bench-driven inputs
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  tx_fifo_byte = 8'h0;
  logic        tx_fifo_eop = 1'b0;
  logic [8:0]  tx_fifo_level = 9'h0;
  logic        slow = 1'b0;
  // design outputs
  wire logic        awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic        tx_fifo_rd, tx_fill, tx_bit, tx_bit_en, rx_bit_en, rx_bit_in;
  // bench state
  int          n_errors = 0;
  int          tests_run = 0;
  logic [31:0] lfsr = 32'd97279;
  logic [8:0]  txq[$];
  logic [7:0]  dq[$];
  logic [11:0] rxq[$];
  logic [31:0] d;
  logic [1:0]  r;
  logic [15:0] c;

  always #5 aclk = ~aclk;

  hope_engine hope_engine_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .tx_fifo_byte, .tx_fifo_eop, .tx_fifo_level, .tx_fifo_rd, .tx_fill,
    .tx_bit_en, .tx_bit, .rx_bit_en, .rx_bit_in);

  hope_framer_model hope_framer_model_i (.aclk, .aresetn, .slow, .tx_bit, .tx_bit_en,
    .rx_bit_en, .rx_bit_in);

  // show-ahead transmit fifo, popped on the read pulse
  always @(posedge aclk) begin
    if (tx_fifo_rd && txq.size() != 0)
      void'(txq.pop_front());
    tx_fifo_level <= 9'(txq.size());
    {tx_fifo_eop, tx_fifo_byte} <= (txq.size() != 0) ? txq[0] : 9'h1a5;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  // reflected crc over the first n bytes, line order bit 0 first
  function automatic logic [15:0] crc(int n);
    logic [15:0] s = 16'hffff;
    for (int i = 0; i < n; i++)
      for (int k = 0; k < 8; k++)
        s = (s[0] ^ dq[i][k]) ? ((s >> 1) ^ 16'h8408) : (s >> 1);
    return s;
  endfunction : crc

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // fill tag must be low whenever a fifo byte is consumed
  always @(posedge aclk)
    if (aresetn && tx_fifo_rd === 1'b1) check("fill during read", tx_fill, 1'b0);

  task automatic wr(logic [3:0] a, logic [31:0] v, logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", bresp, er);
  endtask : wr

  task automatic rd(logic [3:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    rr = rresp;
  endtask : rd

  // queue n bytes at once, the first two mimic abort and flag
  task automatic send(int n, logic last);
    @(posedge aclk);
    dq.delete();
    for (int i = 0; i < n; i++) begin
      dq.push_back(i == 0 ? 8'hff : i == 1 ? 8'h7e : rnd());
      txq.push_back({last && i == n - 1, dq[i]});
    end
  endtask : send

  // read entries until one carries packet end, skipping empty reads
  task automatic get_pkt();
    logic [31:0] v;
    logic [1:0]  rr;
    rxq.delete();
    for (int k = 0; k < 4000; k++) begin
      rd(`HOPE_OFS_RXD, v, rr);
      if (v[12] === 1'b0) begin
        rxq.push_back(v[11:0]);
        if (v[9] !== 1'b0) break;
      end
    end
  endtask : get_pkt

  task automatic cmp();
    check("packet length", rxq.size(), dq.size());
    foreach (dq[i])
      check("packet entry", i < rxq.size() ? rxq[i] : 12'hfff,
            {2'b00, i == dq.size() - 1, i == 0, dq[i]});
  endtask : cmp

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // watchdog, far beyond the expected run
  initial begin
    #800000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and access kinds
    rd(`HOPE_OFS_CTRL, d, r);
    check("ctrl reset", d, 32'h105);
    rd(`HOPE_OFS_THR, d, r);
    check("thr reset", d, 32'h1);
    wr(`HOPE_OFS_THR, 32'h3, `HOPE_RESP_OK);
    rd(`HOPE_OFS_THR, d, r);
    check("thr write", d, 32'h3);
    check("tx fill idle", tx_fill, 1'b1);
    rd(`HOPE_OFS_STAT, d, r);
    check("stat reset", d[4:0], 5'h01);
    rd(`HOPE_OFS_RXD, d, r);
    check("empty read", d[12:0], 13'h1000);
    wr(`HOPE_OFS_RXD, 32'h0, `HOPE_RESP_ERR);
    $display("test registers done");
    // every combination of order, fcs, fill and inversion
    for (int i = 0; i < 16; i++) begin
      wr(`HOPE_OFS_CTRL, {i[0], i[1], i[3], i[3], i[2], 1'b0, i[0], i[1], 1'b1}, `HOPE_RESP_OK);
      slow <= rnd() > 8'h80;
      send(2 + rnd() % 8, 1'b1);
      get_pkt();
      cmp();
    end
    $display("test modes done");
    // fcs bytes seen raw: inverted, then error insertion
    for (int j = 0; j < 2; j++) begin
      wr(`HOPE_OFS_CTRL, j ? 32'h00d : 32'h005, `HOPE_RESP_OK);
      send(5, 1'b1);
      c = crc(5) ^ (j ? 16'h0 : 16'hffff);
      dq.push_back(c[7:0]);
      dq.push_back(c[15:8]);
      get_pkt();
      cmp();
    end
    // raw crc with receive checking on: packet tagged as fcs error
    wr(`HOPE_OFS_CTRL, 32'h10d, `HOPE_RESP_OK);
    send(4, 1'b1);
    get_pkt();
    check("fcs error length", rxq.size(), 4);
    check("fcs error tag", rxq.size() ? rxq[$][11] : 1'b0, 1'b1);
    $display("test fcs done");
    // underrun mid-packet, then recovery
    wr(`HOPE_OFS_CTRL, 32'h105, `HOPE_RESP_OK);
    send(6, 1'b0);
    get_pkt();
    check("abort tag", rxq.size() ? rxq[$][10:9] : 2'b00, 2'b11);
    check("fill after abort", tx_fill, 1'b1);
    send(4, 1'b1);
    get_pkt();
    cmp();
    $display("test abort done");
    // overflow with one long packet left unread
    wr(`HOPE_OFS_CTRL, 32'h001, `HOPE_RESP_OK);
    slow <= 1'b0;
    send(260, 1'b1);
    d = 32'h0;
    for (int k = 0; k < 4000 && d[3] !== 1'b1; k++)
      rd(`HOPE_OFS_STAT, d, r);
    check("stat full", d[3:0], 4'he);
    get_pkt();
    check("stored count", rxq.size(), 256);
    check("overflow tag", rxq.size() ? rxq[$][10:9] : 2'b00, 2'b11);
    rd(`HOPE_OFS_STAT, d, r);
    check("stat drained", d[3:0], 4'h9);
    wr(`HOPE_OFS_STAT, 32'h8, `HOPE_RESP_OK);
    rd(`HOPE_OFS_STAT, d, r);
    check("overflow cleared", d[3], 1'b0);
    send(3, 1'b1);
    get_pkt();
    cmp();
    $display("test overflow done");
    report_and_stop();
  end
endmodule : tb
